// ===== core/fifs_pkg.sv
package fifs_pkg;
	// memory-mapped window, byte offsets of record 0
	localparam logic [11:0] STATUS_BASE = 12'h010;
	localparam logic [11:0] ADDR_BASE   = 12'h018;
	localparam logic [11:0] NCTL_BASE   = 12'h008;
	localparam logic [11:0] FEAT_BASE   = 12'h800;
	localparam logic [11:0] REC_STRIDE  = 12'h040;

	// system-register path selectors
	localparam logic [1:0] SYS_STATUS = 2'h0;
	localparam logic [1:0] SYS_FEAT   = 2'h1;

	// primary status field positions
	localparam int ST_AV   = 31;
	localparam int ST_V    = 30;
	localparam int ST_UE   = 29;
	localparam int ST_ER   = 28;
	localparam int ST_OF   = 27;
	localparam int ST_MV   = 26;
	localparam int ST_CI   = 24;
	localparam int ST_PN   = 22;
	localparam int ST_IERR = 8;
	localparam int IERR_W  = 8;

	// capability descriptor field positions
	localparam int FG_AV = 11;
	localparam int FG_PN = 10;
	localparam int FG_ER = 9;
	localparam int FG_CI = 8;
	localparam int FG_CE = 6;
	localparam int FG_DE = 5;
	localparam int FG_UEO = 4;
	localparam int FG_UER = 3;
	localparam int FG_UEU = 2;
	localparam int FG_UC  = 1;
	localparam int FG_OF  = 0;

	// corrected-generation encodings
	localparam logic [1:0] CE_NONE       = 2'h0;
	localparam logic [1:0] CE_NONSPEC    = 2'h1;
	localparam logic [1:0] CE_TRANS_PERS = 2'h3;

	// node control: interrupt enable position
	localparam int NCTL_IRQ_EN = 0;

	// reset values
	localparam logic [63:0] STATUS_RST = 64'h0;
	localparam logic [63:0] ADDR_RST   = 64'h0;
	localparam logic        NCTL_RST   = 1'b0;
	localparam logic [63:0] RDATA_RST  = 64'h0;
endpackage

// ===== core/fifs_fault_addr.sv
`timescale 1ns/1ps
module fifs_fault_addr (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// software side
	input  wire logic        sw_we,
	input  wire logic [63:0] sw_wdata,
	input  wire logic        addr_valid,
	// hardware recording side
	input  wire logic        hw_we,
	input  wire logic [63:0] hw_addr,
	// held address
	output logic      [63:0] addr_ff
);
	logic [63:0] nxt_addr;

	// a recorded error wins over a software write in the same cycle
	always_comb
	begin
		nxt_addr = addr_ff;
		if (hw_we)
			nxt_addr = hw_addr;
		else if (sw_we && !addr_valid)
			nxt_addr = sw_wdata;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			addr_ff <= fifs_pkg::ADDR_RST;
		else
			addr_ff <= nxt_addr;
	end
endmodule // fifs_fault_addr

// ===== core/fifs_status_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - no address override: update address and valid together
// - address override: keep address, valid from control
// - address register writable while address invalid
// - poison override copies control poison bit
// - abort-reported override copies control bit
// - critical override copies control critical bit
// - overflow override copies control overflow bit
// - corrected-generation field reads legal codes only
// - postponed generation bit shows capability
// - latent generation bit shows capability
// - recoverable generation bit shows capability
// - unrecoverable generation bit shows capability
// - uncontainable generation bit shows capability
// - writing zero returns syndrome to initial state
// - zero syndrome withdraws interrupt request
// - status mapped at 0x010 plus 64 per record
// - reserved status bits read zero
// - address-valid bit is write-one-to-clear
// - address-valid cleared by cold reset, kept through recovery reset
// - interrupt request disabled until software enables
// - record-valid bit set on record, one-to-clear
module fifs_status_regs #(
	parameter int         REC_IDX = 0,
	parameter logic       CAP_AV  = 1'b1,
	parameter logic       CAP_PN  = 1'b1,
	parameter logic       CAP_ER  = 1'b1,
	parameter logic       CAP_CI  = 1'b1,
	parameter logic       CAP_OF  = 1'b1,
	parameter logic [1:0] CAP_CE  = 2'h1,
	parameter logic       CAP_DE  = 1'b1,
	parameter logic       CAP_UEO = 1'b0,
	parameter logic       CAP_UER = 1'b1,
	parameter logic       CAP_UEU = 1'b1,
	parameter logic       CAP_UC  = 1'b0
) (
	// clock and resets
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        err_reset,
	// memory-mapped window
	input  wire logic        mm_req,
	input  wire logic        mm_we,
	input  wire logic [11:0] mm_addr,
	input  wire logic [63:0] mm_wdata,
	output logic      [63:0] mm_rdata_ff,
	output logic             mm_ack_ff,
	// 32-bit system-register path
	input  wire logic        sys_req,
	input  wire logic        sys_we,
	input  wire logic [4:0]  sys_sel,
	input  wire logic [1:0]  sys_reg,
	input  wire logic [31:0] sys_wdata,
	output logic      [31:0] sys_rdata_ff,
	output logic             sys_ack_ff,
	// error recording
	input  wire logic        rec_pulse,
	input  wire logic        rec_injected,
	input  wire logic        rec_ue,
	input  wire logic        rec_er,
	input  wire logic        rec_pn,
	input  wire logic        rec_ci,
	input  wire logic        rec_mv,
	input  wire logic        rec_addr_valid,
	input  wire logic [63:0] rec_addr,
	input  wire logic [7:0]  rec_ierr,
	// injection control bits
	input  wire logic        ctl_av,
	input  wire logic        ctl_pn,
	input  wire logic        ctl_er,
	input  wire logic        ctl_ci,
	input  wire logic        ctl_of,
	// state seen outside
	output logic      [63:0] status_ff,
	output logic      [63:0] fault_addr_ff,
	output logic             fault_irq_ff
);
	localparam logic [11:0] REC_OFF =
		12'(fifs_pkg::REC_STRIDE * REC_IDX);
	localparam logic [11:0] ST_OFF = fifs_pkg::STATUS_BASE + REC_OFF;
	localparam logic [11:0] AD_OFF = fifs_pkg::ADDR_BASE + REC_OFF;
	localparam logic [11:0] NC_OFF = fifs_pkg::NCTL_BASE + REC_OFF;
	localparam logic [11:0] FG_OFF = fifs_pkg::FEAT_BASE + REC_OFF;
	localparam logic [4:0]  SEL_ID = 5'(REC_IDX);

	// a reserved code would mislead software, so it reads as none
	localparam logic [1:0] CE_RD =
		(CAP_CE == fifs_pkg::CE_NONSPEC ||
		 CAP_CE == fifs_pkg::CE_TRANS_PERS) ?
		CAP_CE : fifs_pkg::CE_NONE;

	logic [63:0] feat_id;
	logic        st_wr;
	logic [63:0] st_wdata;
	logic        addr_wr;
	logic        nctl_wr;
	logic        ovr;
	logic        addr_hw_we;
	logic [63:0] nxt_status;
	logic        nxt_irq_en;
	logic        irq_en_ff;
	logic        nxt_irq;
	logic [63:0] nxt_mm_rdata;
	logic [31:0] nxt_sys_rdata;
	logic        mm_hit_st;
	logic        sys_hit;

	// descriptor is wired from parameters; no store, so writes vanish
	always_comb
	begin
		feat_id = 64'h0;
		feat_id[fifs_pkg::FG_AV] = CAP_AV;
		feat_id[fifs_pkg::FG_PN] = CAP_PN;
		feat_id[fifs_pkg::FG_ER] = CAP_ER;
		feat_id[fifs_pkg::FG_CI] = CAP_CI;
		feat_id[fifs_pkg::FG_CE +: 2] = CE_RD;
		feat_id[fifs_pkg::FG_DE] = CAP_DE;
		feat_id[fifs_pkg::FG_UEO] = CAP_UEO;
		feat_id[fifs_pkg::FG_UER] = CAP_UER;
		feat_id[fifs_pkg::FG_UEU] = CAP_UEU;
		feat_id[fifs_pkg::FG_UC] = CAP_UC;
		feat_id[fifs_pkg::FG_OF] = CAP_OF;
	end

	// write decode; the window wins a clash, the system write is dropped
	always_comb
	begin
		mm_hit_st = mm_req && mm_we && (mm_addr == ST_OFF);
		sys_hit = sys_req && (sys_sel == SEL_ID);
		st_wr = mm_hit_st ||
			(sys_hit && sys_we && sys_reg == fifs_pkg::SYS_STATUS);
		st_wdata = mm_hit_st ? mm_wdata : {32'h0, sys_wdata};
		addr_wr = mm_req && mm_we && (mm_addr == AD_OFF);
		nctl_wr = mm_req && mm_we && (mm_addr == NC_OFF);
	end

	// address capture: plain records and injected ones without override
	always_comb
	begin
		ovr = rec_pulse && rec_injected;
		addr_hw_we = rec_pulse && rec_addr_valid &&
			!(rec_injected && CAP_AV);
	end

	fifs_fault_addr u_fault_addr (
		.mclk       (mclk),
		.reset      (reset),
		.sw_we      (addr_wr),
		.sw_wdata   (mm_wdata),
		.addr_valid (status_ff[fifs_pkg::ST_AV]),
		.hw_we      (addr_hw_we),
		.hw_addr    (rec_addr),
		.addr_ff    (fault_addr_ff)
	);

	// status next value: software clears first, a record then sets,
	// so an event in the clearing cycle is never lost
	always_comb
	begin
		nxt_status = status_ff;
		if (st_wr)
		begin
			nxt_status[fifs_pkg::ST_AV] = status_ff[fifs_pkg::ST_AV] &
				~st_wdata[fifs_pkg::ST_AV];
			nxt_status[fifs_pkg::ST_V] = status_ff[fifs_pkg::ST_V] &
				~st_wdata[fifs_pkg::ST_V];
			nxt_status[fifs_pkg::ST_UE] = status_ff[fifs_pkg::ST_UE] &
				~st_wdata[fifs_pkg::ST_UE];
			nxt_status[fifs_pkg::ST_ER] = status_ff[fifs_pkg::ST_ER] &
				~st_wdata[fifs_pkg::ST_ER];
			nxt_status[fifs_pkg::ST_OF] = status_ff[fifs_pkg::ST_OF] &
				~st_wdata[fifs_pkg::ST_OF];
			nxt_status[fifs_pkg::ST_MV] = status_ff[fifs_pkg::ST_MV] &
				~st_wdata[fifs_pkg::ST_MV];
			nxt_status[fifs_pkg::ST_CI] = status_ff[fifs_pkg::ST_CI] &
				~st_wdata[fifs_pkg::ST_CI];
			nxt_status[fifs_pkg::ST_PN] = status_ff[fifs_pkg::ST_PN] &
				~st_wdata[fifs_pkg::ST_PN];
			// syndrome takes any value, zero restores the initial state
			nxt_status[fifs_pkg::ST_IERR +: fifs_pkg::IERR_W] =
				st_wdata[fifs_pkg::ST_IERR +: fifs_pkg::IERR_W];
		end
		if (rec_pulse)
		begin
			nxt_status[fifs_pkg::ST_V] = 1'b1;
			if (rec_ue)
				nxt_status[fifs_pkg::ST_UE] = 1'b1;
			if (rec_mv)
				nxt_status[fifs_pkg::ST_MV] = 1'b1;
			nxt_status[fifs_pkg::ST_IERR +: fifs_pkg::IERR_W] = rec_ierr;
			// address valid
			if (ovr && CAP_AV)
				nxt_status[fifs_pkg::ST_AV] = ctl_av;
			else if (rec_addr_valid)
				nxt_status[fifs_pkg::ST_AV] = 1'b1;
			// poison
			if (ovr && CAP_PN)
				nxt_status[fifs_pkg::ST_PN] = ctl_pn;
			else if (rec_pn)
				nxt_status[fifs_pkg::ST_PN] = 1'b1;
			// abort reported follows the uncorrected error normally
			if (ovr && CAP_ER)
				nxt_status[fifs_pkg::ST_ER] = ctl_er;
			else if (rec_er && rec_ue)
				nxt_status[fifs_pkg::ST_ER] = 1'b1;
			// critical
			if (ovr && CAP_CI)
				nxt_status[fifs_pkg::ST_CI] = ctl_ci;
			else if (rec_ci)
				nxt_status[fifs_pkg::ST_CI] = 1'b1;
			// overflow: a record landing on an already valid status
			if (ovr && CAP_OF)
				nxt_status[fifs_pkg::ST_OF] = ctl_of;
			else if (status_ff[fifs_pkg::ST_V])
				nxt_status[fifs_pkg::ST_OF] = 1'b1;
		end
		nxt_status[63:32] = 32'h0;
		nxt_status[18:16] = 3'h0;
	end

	// interrupt enable starts off and only software turns it on;
	// the recovery reset also drops it so a stale request cannot fire
	always_comb
	begin
		nxt_irq_en = irq_en_ff;
		if (err_reset)
			nxt_irq_en = fifs_pkg::NCTL_RST;
		else if (nctl_wr)
			nxt_irq_en = mm_wdata[fifs_pkg::NCTL_IRQ_EN];
		nxt_irq = irq_en_ff &&
			(|status_ff[fifs_pkg::ST_IERR +: fifs_pkg::IERR_W]);
	end

	// read mux; unmapped window offsets read zero
	always_comb
	begin
		nxt_mm_rdata = mm_rdata_ff;
		if (mm_req && !mm_we)
		begin
			case (mm_addr)
				ST_OFF:  nxt_mm_rdata = status_ff;
				AD_OFF:  nxt_mm_rdata = fault_addr_ff;
				NC_OFF:  nxt_mm_rdata = {63'h0, irq_en_ff};
				FG_OFF:  nxt_mm_rdata = feat_id;
				default: nxt_mm_rdata = 64'h0;
			endcase
		end
		nxt_sys_rdata = sys_rdata_ff;
		if (sys_req && !sys_we)
		begin
			nxt_sys_rdata = 32'h0;
			if (sys_hit && sys_reg == fifs_pkg::SYS_STATUS)
				nxt_sys_rdata = status_ff[31:0];
			else if (sys_hit && sys_reg == fifs_pkg::SYS_FEAT)
				nxt_sys_rdata = feat_id[31:0];
		end
	end

	// cold reset clears everything; recovery reset keeps the record
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			status_ff    <= fifs_pkg::STATUS_RST;
			irq_en_ff    <= fifs_pkg::NCTL_RST;
			fault_irq_ff <= 1'b0;
			mm_rdata_ff  <= fifs_pkg::RDATA_RST;
			mm_ack_ff    <= 1'b0;
			sys_rdata_ff <= 32'h0;
			sys_ack_ff   <= 1'b0;
		end
		else
		begin
			status_ff    <= nxt_status;
			irq_en_ff    <= nxt_irq_en;
			fault_irq_ff <= nxt_irq;
			mm_rdata_ff  <= nxt_mm_rdata;
			mm_ack_ff    <= mm_req;
			sys_rdata_ff <= nxt_sys_rdata;
			sys_ack_ff   <= sys_req;
		end
	end
endmodule // fifs_status_regs

// ===== testbench/fifs_status_checker.sv
`timescale 1ns/1ps
module fifs_status_checker (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// requests
	input wire logic        mm_req,
	input wire logic        sys_req,
	input wire logic        rec_pulse,
	input wire logic        rec_injected,
	// injection control
	input wire logic        ctl_av,
	input wire logic        ctl_pn,
	input wire logic        ctl_er,
	input wire logic        ctl_ci,
	input wire logic        ctl_of,
	// answers and state
	input wire logic        mm_ack_ff,
	input wire logic        sys_ack_ff,
	input wire logic [63:0] status_ff,
	input wire logic [63:0] fault_addr_ff,
	input wire logic        fault_irq_ff
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	sequence inj_rec_s;
		rec_pulse && rec_injected && !mm_req;
	endsequence
	sequence plain_rec_s;
		rec_pulse && !rec_injected;
	endsequence
	mm_ack_a:
		assert property (mm_req |=> mm_ack_ff) else $error("window ack missing");
	sys_ack_a:
		assert property (sys_req |=> sys_ack_ff) else $error("sys ack missing");
	resv_zero_a:
		assert property (status_ff[63:32] == 32'h0 && status_ff[18:16] == 3'h0)
		else $error("reserved status bits set");
	rec_valid_a:
		assert property (rec_pulse |=> status_ff[30]) else $error("valid not set");
	inj_flags_a:
		assert property (inj_rec_s |=> {status_ff[22], status_ff[24],
			status_ff[28], status_ff[27]} == $past({ctl_pn, ctl_ci, ctl_er, ctl_of}))
		else $error("injected flags not copied");
	inj_addr_a:
		assert property (inj_rec_s |=> status_ff[31] == $past(ctl_av)
			&& $stable(fault_addr_ff)) else $error("injected address handling");
	of_normal_a:
		assert property (plain_rec_s ##0 status_ff[30] |=> status_ff[27])
		else $error("overflow not set on second record");
	irq_cause_a:
		assert property (fault_irq_ff |-> $past(status_ff[15:8]) != 8'h0)
		else $error("irq without syndrome");
	irq_off_a:
		assert property (status_ff[15:8] == 8'h0 |=> !fault_irq_ff)
		else $error("irq stays after syndrome cleared");
	valid_hold_a:
		assert property (!mm_req && !sys_req && !rec_pulse |=>
			$stable(status_ff[31:30])) else $error("valid bits moved");
endmodule // fifs_status_checker
bind fifs_status_regs fifs_status_checker fifs_status_checker_i (.*);

// ===== testbench/fifs_status_regs_tb_top.sv
`timescale 1ns/1ps
module fifs_status_regs_tb_top;
	logic mclk = 0, reset = 1, err_reset = 0, mm_req = 0, mm_we = 0;
	logic sys_req = 0, sys_we = 0, mm_ack_ff, sys_ack_ff, fault_irq_ff;
	logic [11:0] mm_addr = 0;
	logic [63:0] mm_wdata = 0, rec_addr = 0, mm_rdata_ff, status_ff;
	logic [63:0] fault_addr_ff, ex, a0;
	logic [4:0] sys_sel = 0;
	logic [1:0] sys_reg = 0;
	logic [31:0] sys_wdata = 0, sys_rdata_ff;
	logic rec_pulse = 0, rec_injected = 0, rec_ue = 0, rec_er = 0;
	logic rec_pn = 0, rec_ci = 0, rec_mv = 0, rec_addr_valid = 0;
	logic [7:0] rec_ierr = 0;
	logic ctl_av = 0, ctl_pn = 0, ctl_er = 0, ctl_ci = 0, ctl_of = 0;
	int bad_count = 0, samples_checked = 0, cyc = 0;
	// record 1 sits one stride above record 0
	localparam logic [11:0] OFS = fifs_pkg::REC_STRIDE;
	// default capabilities: four overrides, corrected code 01,
	// postponed, recoverable, unrecoverable and overflow override
	localparam logic [63:0] FEAT = {52'h0, 4'hF, 2'h1, 6'b101101};

	fifs_status_regs #(.REC_IDX(1)) fifs_status_regs_i (.*);

	always #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(logic [63:0] seen, logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic mm(logic we, logic [11:0] a, logic [63:0] d);
		@(posedge mclk);
		mm_req <= 1'b1;
		mm_we <= we;
		mm_addr <= a + OFS;
		mm_wdata <= d;
		@(posedge mclk);
		mm_req <= 1'b0;
		#1;
	endtask

	task automatic sys(logic we, logic [4:0] s, logic [1:0] r, logic [31:0] d);
		@(posedge mclk);
		sys_req <= 1'b1;
		sys_we <= we;
		sys_sel <= s;
		sys_reg <= r;
		sys_wdata <= d;
		@(posedge mclk);
		sys_req <= 1'b0;
		#1;
	endtask

	task automatic rec(logic inj);
		@(posedge mclk);
		{rec_ue, rec_er, rec_pn, rec_ci, rec_mv, rec_addr_valid} <= 6'($urandom);
		{ctl_av, ctl_pn, ctl_er, ctl_ci, ctl_of} <= 5'($urandom);
		rec_ierr <= 8'($urandom);
		rec_addr <= {$urandom, $urandom};
		rec_injected <= inj;
		rec_pulse <= 1'b1;
		@(posedge mclk);
		rec_pulse <= 1'b0;
	endtask

	// status after one record from a cleared state
	function automatic logic [63:0] st_exp();
		st_exp = 64'h0;
		st_exp[fifs_pkg::ST_V] = 1'b1;
		st_exp[fifs_pkg::ST_UE] = rec_ue;
		st_exp[fifs_pkg::ST_MV] = rec_mv;
		st_exp[15:8] = rec_ierr;
		st_exp[fifs_pkg::ST_AV] = rec_injected ? ctl_av : rec_addr_valid;
		st_exp[fifs_pkg::ST_PN] = rec_injected ? ctl_pn : rec_pn;
		st_exp[fifs_pkg::ST_CI] = rec_injected ? ctl_ci : rec_ci;
		st_exp[fifs_pkg::ST_ER] = rec_injected ? ctl_er : rec_er & rec_ue;
		st_exp[fifs_pkg::ST_OF] = rec_injected & ctl_of;
	endfunction

	initial
	begin
		void'($urandom(32'h82c7));
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		mm(1'b1, fifs_pkg::FEAT_BASE, {$urandom, $urandom});
		mm(1'b0, fifs_pkg::FEAT_BASE, 64'h0);
		chk(mm_rdata_ff, FEAT);
		sys(1'b0, 5'h1, fifs_pkg::SYS_FEAT, 32'h0);
		chk({32'h0, sys_rdata_ff}, FEAT);
		mm(1'b0, 12'h100, 64'h0);
		chk(mm_rdata_ff, 64'h0);
		for (int i = 0; i < 12; i++)
		begin
			mm(1'b1, fifs_pkg::STATUS_BASE, 64'hFFFF_FFFF_FFFF_00FF);
			mm(1'b0, fifs_pkg::STATUS_BASE, 64'h0);
			chk(mm_rdata_ff, 64'h0);
			a0 = {$urandom, $urandom};
			mm(1'b1, fifs_pkg::ADDR_BASE, a0);
			chk(fault_addr_ff, a0);
			rec(i[0]);
			@(posedge mclk);
			err_reset <= 1'b1;
			@(posedge mclk);
			err_reset <= 1'b0;
			#1;
			ex = st_exp();
			chk(status_ff, ex);
			chk(fault_addr_ff, !i[0] && rec_addr_valid ? rec_addr : a0);
			sys(1'b0, 5'h1, fifs_pkg::SYS_STATUS, 32'h0);
			chk({32'h0, sys_rdata_ff}, {32'h0, ex[31:0]});
			sys(1'b1, 5'h1, fifs_pkg::SYS_STATUS, {1'b1, 15'h0, rec_ierr, 8'h0});
			ex[fifs_pkg::ST_AV] = 1'b0;
			chk(status_ff, ex);
		end
		rec(1'b0);
		rec(1'b0);
		#1;
		chk({63'h0, status_ff[fifs_pkg::ST_OF]}, 64'h1);
		sys(1'b0, 5'h0, fifs_pkg::SYS_STATUS, 32'h0);
		chk({32'h0, sys_rdata_ff}, 64'h0);
		mm(1'b1, fifs_pkg::STATUS_BASE, 64'hFFFF_FFFF_FFFF_A5FF);
		repeat (2) @(posedge mclk);
		#1;
		chk({63'h0, fault_irq_ff}, 64'h0);
		mm(1'b1, fifs_pkg::NCTL_BASE, 64'h1);
		repeat (2) @(posedge mclk);
		#1;
		chk({63'h0, fault_irq_ff}, 64'h1);
		// recovery reset drops the enable, so the request must go
		@(posedge mclk);
		err_reset <= 1'b1;
		@(posedge mclk);
		err_reset <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk({63'h0, fault_irq_ff}, 64'h0);
		mm(1'b1, fifs_pkg::NCTL_BASE, 64'h1);
		repeat (2) @(posedge mclk);
		#1;
		chk({63'h0, fault_irq_ff}, 64'h1);
		mm(1'b1, fifs_pkg::STATUS_BASE, 64'h0);
		repeat (2) @(posedge mclk);
		#1;
		chk({63'h0, fault_irq_ff}, 64'h0);
		rec(1'b0);
		@(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		#1;
		chk(status_ff, 64'h0);
		tally_and_finish();
	end
endmodule // fifs_status_regs_tb_top
